// file: core/i2c_seq_pkg.sv
package i2c_seq_pkg;

   // ----------------------------------------------------------------
   // Register map, word aligned on the APB.
   // ----------------------------------------------------------------
   localparam int         PADDR_W   = 8;
   localparam int         PDATA_W   = 32;
   localparam logic [7:0] OFF_CTRL  = 8'h00;
   localparam logic [7:0] OFF_STAT  = 8'h04;
   localparam logic [7:0] OFF_DATA  = 8'h08;
   localparam logic [7:0] OFF_RATE  = 8'h0C;

   // ----------------------------------------------------------------
   // Control register bit positions.
   // ----------------------------------------------------------------
   localparam int C_PORT_EN = 0;
   localparam int C_START   = 1;
   localparam int C_STOP    = 2;
   localparam int C_RECEIVE_ENABLE_BIT    = 3;
   localparam int C_ACK_SEQUENCE_ENABLE   = 4;
   localparam int C_ACK_DATA_BIT   = 5;
   localparam int C_IRQ_EN  = 6;

   // ----------------------------------------------------------------
   // Status register bit positions.
   // ----------------------------------------------------------------
   localparam int S_BF      = 0;
   localparam int S_OV      = 1;
   localparam int S_WRITE_COLLISION_FLAG    = 2;
   localparam int S_BCOL    = 3;
   localparam int S_EVT     = 4;
   localparam int S_START   = 5;
   localparam int S_STOP    = 6;
   localparam int S_FREE    = 7;
   localparam int S_ACKSTAT = 8;
   localparam int S_BUSY    = 9;

   // ----------------------------------------------------------------
   // Widths, counts and reset values.
   // ----------------------------------------------------------------
   localparam int         RATE_W    = 7;
   localparam logic [6:0] RATE_RST  = 7'h04;
   localparam logic [3:0] RX_LAST   = 4'h7;
   localparam logic [3:0] TX_LAST   = 4'h8;
   localparam logic [2:0] PH_0      = 3'h0;
   localparam logic [2:0] PH_1      = 3'h1;
   localparam logic [2:0] PH_2      = 3'h2;
   localparam logic [2:0] PH_3      = 3'h3;
   localparam logic [2:0] PH_4      = 3'h4;
   localparam logic [2:0] PH_5      = 3'h5;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_START = 3'b001,
      ST_STOP  = 3'b010,
      ST_ACK   = 3'b011,
      ST_XFER  = 3'b100
   } seq_state_t;

endpackage

// file: core/sync2.sv
`timescale 1ns/10ps

// Two-stage synchroniser for the open-drain bus lines; idles high.
module sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta;

   // ----------------------------------------------------------------
   // The first stage feeds only the second stage.
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= '1;
         q    <= '1;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end

endmodule

// file: core/i2c_master_seq.sv
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/10ps

// Notes on behaviour
// - Sequence enable bits written while the sequencer is busy are ignored.
// - Receive: baud counter runs, SCL toggles per rollover, SDA shifted in.
// - Eighth receive fall: clear enable, load buffer, set flags, hold SCL low.
// - Buffer full sets on byte load and clears when software reads data.
// - Overflow sets when a byte completes while buffer full is still set.
// - Data write during receive, ack or stop sets write collision, dropped.
// - Ack: SCL low, drive ack bit, release, wait high, count, SCL low.
// - Stop: SDA low, wait low, count, release SCL, count, release SDA.
// - Stop seen on SDA high with SCL high; one period later event, idle.
// - In sleep a completed byte wakes the processor if interrupt enabled.
// - Reset disables the port and abandons any transfer.
// - Start and stop seen flags clear on reset and while disabled.
// - Bus free if stop seen or neither seen; stop on busy bus raises event.
// - Released SDA read low with SCL high sets bus collision, goes idle.
// - Transmit collision halts, clears buffer full, releases both lines.
// - Sequence collision aborts, releases lines, clears enable bits.
// - After losing arbitration a bus stop still raises the port event.
// - After a collision a new data write restarts from the first bit.
// - Start with SDA or SCL already low aborts with bus collision.
// - Start: count from rate reload; SCL low while SDA high collides.
// - SDA low early drives SDA low early; recount, then pull SCL low.
// - Released SCL pauses counting until SCL reads high, then reloads.
module i2c_master_seq
   import i2c_seq_pkg::*;
#(
   parameter logic [RATE_W-1:0] RATE_RESET = RATE_RST
) (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [PADDR_W-1:0] paddr,
   input  wire logic [PDATA_W-1:0] pwdata,
   output logic      [PDATA_W-1:0] prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire logic               scl_in,
   output logic                    scl_out,
   output logic                    scl_oe,
   input  wire logic               sda_in,
   output logic                    sda_out,
   output logic                    sda_oe,
   input  wire logic               sleep_mode,
   output logic                    port_irq,
   output logic                    wake
);

   // ----------------------------------------------------------------
   // Declarations.
   // ----------------------------------------------------------------
   seq_state_t        state;
   logic [2:0]        phase;
   logic [RATE_W-1:0] rate_reload;
   logic [RATE_W-1:0] baud_generator;
   logic [3:0]        bitcnt;
   logic [7:0]        shift_register;
   logic [7:0]        data_buffer;
   logic              port_en;
   logic              ack_data_bit;
   logic              irq_en;
   logic              start_enable;
   logic              stop_enable_bit;
   logic              receive_enable_bit;
   logic              ack_sequence_enable;
   logic              tx_mode;
   logic              buffer_full_flag;
   logic              receive_overflow_flag;
   logic              write_collision_flag;
   logic              bus_collision_flag;
   logic              port_event_flag;
   logic              ack_status;
   logic              start_seen_flag;
   logic              stop_seen_flag;
   logic [1:0]        pins_s;
   logic              scl_s;
   logic              sda_s;
   logic              scl_q;
   logic              sda_q;
   logic              start_det;
   logic              stop_det;
   logic              tick;
   logic              collide;
   logic              xfer_end;
   logic              wr_done;
   logic              rd_done;
   logic              ctrl_wr;
   logic              stat_wr;
   logic              data_wr;
   logic              data_rd;
   logic              any_cmd;
   logic              mapped;
   logic [PDATA_W-1:0] rd_val;

   // ----------------------------------------------------------------
   // Pin sampling and bus condition detection.
   // ----------------------------------------------------------------
   sync2 #(
      .W (2)
   ) u_pin_sync (
      .clk   (pclk),
      .rst_n (presetn),
      .d     ({scl_in, sda_in}),
      .q     (pins_s)
   );

   assign scl_s = pins_s[1];
   assign sda_s = pins_s[0];

   // Previous samples give the edges of SDA while SCL stays high.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
      end
   end

   assign start_det = scl_s & scl_q & sda_q & ~sda_s;
   assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;

   // Bus occupancy is tracked even while this master is not driving.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_seen_flag <= 1'b0;
         stop_seen_flag  <= 1'b0;
      end else if (!port_en) begin
         start_seen_flag <= 1'b0;
         stop_seen_flag  <= 1'b0;
      end else if (start_det) begin
         start_seen_flag <= 1'b1;
         stop_seen_flag  <= 1'b0;
      end else if (stop_det) begin
         start_seen_flag <= 1'b0;
         stop_seen_flag  <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // APB slave: no wait states, answer registered at setup.
   // ----------------------------------------------------------------
   assign wr_done = psel & penable & pready & pwrite;
   assign rd_done = psel & penable & pready & ~pwrite;
   assign ctrl_wr = wr_done & (paddr == OFF_CTRL);
   assign stat_wr = wr_done & (paddr == OFF_STAT);
   assign data_wr = wr_done & (paddr == OFF_DATA);
   assign data_rd = rd_done & (paddr == OFF_DATA);
   assign any_cmd = start_enable | stop_enable_bit | receive_enable_bit
                    | ack_sequence_enable;
   assign mapped  = (paddr == OFF_CTRL) | (paddr == OFF_STAT)
                    | (paddr == OFF_DATA) | (paddr == OFF_RATE);

   // Read data multiplexer; unused bits read as zero.
   always_comb begin
      rd_val = '0;
      unique case (paddr)
         OFF_CTRL: begin
            rd_val[C_PORT_EN] = port_en;
            rd_val[C_START]   = start_enable;
            rd_val[C_STOP]    = stop_enable_bit;
            rd_val[C_RECEIVE_ENABLE_BIT]    = receive_enable_bit;
            rd_val[C_ACK_SEQUENCE_ENABLE]   = ack_sequence_enable;
            rd_val[C_ACK_DATA_BIT]   = ack_data_bit;
            rd_val[C_IRQ_EN]  = irq_en;
         end
         OFF_STAT: begin
            rd_val[S_BF]      = buffer_full_flag;
            rd_val[S_OV]      = receive_overflow_flag;
            rd_val[S_WRITE_COLLISION_FLAG]    = write_collision_flag;
            rd_val[S_BCOL]    = bus_collision_flag;
            rd_val[S_EVT]     = port_event_flag;
            rd_val[S_START]   = start_seen_flag;
            rd_val[S_STOP]    = stop_seen_flag;
            rd_val[S_FREE]    = stop_seen_flag | ~start_seen_flag;
            rd_val[S_ACKSTAT] = ack_status;
            rd_val[S_BUSY]    = (state != ST_IDLE);
         end
         OFF_DATA: rd_val[7:0]        = data_buffer;
         OFF_RATE: rd_val[RATE_W-1:0] = rate_reload;
         default:  rd_val = '0;
      endcase
   end

   // Ready rises in the access phase and drops after it completes.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         if (psel && !penable) begin
            prdata <= rd_val;
         end
      end
   end

   // Plain configuration written by software.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_en      <= 1'b0;
         ack_data_bit <= 1'b0;
         irq_en       <= 1'b0;
         rate_reload  <= RATE_RESET;
      end else begin
         if (ctrl_wr) begin
            port_en      <= pwdata[C_PORT_EN];
            ack_data_bit <= pwdata[C_ACK_DATA_BIT];
            irq_en       <= pwdata[C_IRQ_EN];
         end
         if (wr_done && paddr == OFF_RATE) begin
            rate_reload <= pwdata[RATE_W-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Sequencer.
   // ----------------------------------------------------------------
   assign tick     = (baud_generator == '0);
   assign xfer_end = tx_mode ? (bitcnt == TX_LAST) : (bitcnt == RX_LAST);

   // Arbitration losses: a released line seen low, or SCL pulled early.
   always_comb begin
      collide = 1'b0;
      unique case (state)
         ST_START: collide = (phase == PH_0) & ~scl_s & sda_s;
         ST_XFER:  collide = tx_mode & (bitcnt != TX_LAST) & ~sda_oe
                             & (phase == PH_3) & scl_s & ~sda_s;
         ST_ACK:   collide = (phase == PH_3) & ~sda_oe & scl_s & ~sda_s;
         ST_STOP:  collide = (phase == PH_3) & ~scl_s;
         default:  collide = 1'b0;
      endcase
   end

   // Sticky flags are cleared first so a same-cycle set still wins.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state                 <= ST_IDLE;
         phase                 <= PH_0;
         baud_generator                   <= '0;
         bitcnt                <= '0;
         shift_register        <= '0;
         data_buffer           <= '0;
         start_enable          <= 1'b0;
         stop_enable_bit       <= 1'b0;
         receive_enable_bit    <= 1'b0;
         ack_sequence_enable   <= 1'b0;
         tx_mode               <= 1'b0;
         buffer_full_flag      <= 1'b0;
         receive_overflow_flag <= 1'b0;
         write_collision_flag  <= 1'b0;
         bus_collision_flag    <= 1'b0;
         port_event_flag       <= 1'b0;
         ack_status            <= 1'b0;
         scl_oe                <= 1'b0;
         sda_oe                <= 1'b0;
      end else begin
         baud_generator <= tick ? baud_generator : baud_generator - 1'b1;
         if (stat_wr) begin
            receive_overflow_flag <= receive_overflow_flag & ~pwdata[S_OV];
            write_collision_flag  <= write_collision_flag & ~pwdata[S_WRITE_COLLISION_FLAG];
            bus_collision_flag    <= bus_collision_flag & ~pwdata[S_BCOL];
            port_event_flag       <= port_event_flag & ~pwdata[S_EVT];
         end
         if (data_rd) begin
            buffer_full_flag <= 1'b0;
         end
         if (ctrl_wr && state == ST_IDLE && !any_cmd && port_en) begin
            start_enable        <= pwdata[C_START];
            stop_enable_bit     <= pwdata[C_STOP];
            receive_enable_bit  <= pwdata[C_RECEIVE_ENABLE_BIT];
            ack_sequence_enable <= pwdata[C_ACK_SEQUENCE_ENABLE];
         end
         if (data_wr && state != ST_IDLE) begin
            write_collision_flag <= 1'b1;
         end
         if (stop_det && start_seen_flag) begin
            port_event_flag <= 1'b1;
         end
         unique case (state)
            ST_IDLE: begin
               phase <= PH_0;
               if (data_wr && port_en) begin
                  shift_register   <= pwdata[7:0];
                  buffer_full_flag <= 1'b1;
                  tx_mode          <= 1'b1;
                  bitcnt           <= '0;
                  state            <= ST_XFER;
               end else if (start_enable) begin
                  if (!sda_s || !scl_s) begin
                     bus_collision_flag <= 1'b1;
                     start_enable       <= 1'b0;
                  end else begin
                     baud_generator   <= rate_reload;
                     state <= ST_START;
                  end
               end else if (stop_enable_bit) begin
                  sda_oe <= 1'b1;
                  state  <= ST_STOP;
               end else if (receive_enable_bit) begin
                  tx_mode <= 1'b0;
                  bitcnt  <= '0;
                  state   <= ST_XFER;
               end else if (ack_sequence_enable) begin
                  scl_oe <= 1'b1;
                  sda_oe <= ~ack_data_bit;
                  baud_generator    <= rate_reload;
                  phase  <= PH_1;
                  state  <= ST_ACK;
               end
            end
            ST_START: begin
               if (phase == PH_0 && (!sda_s || tick)) begin
                  sda_oe <= 1'b1;
                  baud_generator    <= rate_reload;
                  phase  <= PH_1;
               end else if (phase == PH_1 && tick) begin
                  scl_oe       <= 1'b1;
                  start_enable <= 1'b0;
                  state        <= ST_IDLE;
               end
            end
            ST_STOP: begin
               if (phase == PH_0 && !sda_s) begin
                  baud_generator   <= rate_reload;
                  phase <= PH_1;
               end else if (phase == PH_1 && tick) begin
                  scl_oe <= 1'b0;
                  phase  <= PH_2;
               end else if (phase == PH_2 && scl_s) begin
                  baud_generator   <= rate_reload;
                  phase <= PH_3;
               end else if (phase == PH_3 && tick) begin
                  sda_oe <= 1'b0;
                  phase  <= PH_4;
               end else if (phase == PH_4 && sda_s && scl_s) begin
                  baud_generator   <= rate_reload;
                  phase <= PH_5;
               end else if (phase == PH_5 && tick) begin
                  stop_enable_bit <= 1'b0;
                  port_event_flag <= 1'b1;
                  state           <= ST_IDLE;
               end
            end
            ST_ACK: begin
               if (phase == PH_1 && tick) begin
                  scl_oe <= 1'b0;
                  phase  <= PH_2;
               end else if (phase == PH_2 && scl_s) begin
                  baud_generator   <= rate_reload;
                  phase <= PH_3;
               end else if (phase == PH_3 && tick) begin
                  scl_oe              <= 1'b1;
                  sda_oe              <= 1'b0;
                  ack_sequence_enable <= 1'b0;
                  state               <= ST_IDLE;
               end
            end
            ST_XFER: begin
               // SCL low half then high half
               if (phase == PH_0) begin
                  scl_oe <= 1'b1;
                  sda_oe <= tx_mode & (bitcnt != TX_LAST)
                            & ~shift_register[7];
                  baud_generator    <= rate_reload;
                  phase  <= PH_1;
               end else if (phase == PH_1 && tick) begin
                  scl_oe <= 1'b0;
                  phase  <= PH_2;
               end else if (phase == PH_2 && scl_s) begin
                  baud_generator   <= rate_reload;
                  phase <= PH_3;
                  if (!tx_mode) begin
                     shift_register <= {shift_register[6:0], sda_s};
                  end else if (bitcnt == TX_LAST) begin
                     ack_status <= sda_s;
                  end
               end else if (phase == PH_3 && tick) begin
                  scl_oe <= 1'b1;
                  bitcnt <= bitcnt + 1'b1;
                  phase  <= PH_0;
                  if (tx_mode) begin
                     shift_register <= {shift_register[6:0], 1'b1};
                  end
                  if (tx_mode && bitcnt == RX_LAST) begin
                     buffer_full_flag <= 1'b0;
                  end
                  if (xfer_end) begin
                     sda_oe          <= 1'b0;
                     port_event_flag <= 1'b1;
                     state           <= ST_IDLE;
                     if (!tx_mode) begin
                        data_buffer        <= shift_register;
                        buffer_full_flag   <= 1'b1;
                        receive_enable_bit <= 1'b0;
                        if (buffer_full_flag && !data_rd) begin
                           receive_overflow_flag <= 1'b1;
                        end
                     end
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
         if (collide) begin
            bus_collision_flag  <= 1'b1;
            scl_oe              <= 1'b0;
            sda_oe              <= 1'b0;
            start_enable        <= 1'b0;
            stop_enable_bit     <= 1'b0;
            receive_enable_bit  <= 1'b0;
            ack_sequence_enable <= 1'b0;
            state               <= ST_IDLE;
            if (state == ST_XFER) begin
               buffer_full_flag <= 1'b0;
            end
         end
         if (!port_en) begin
            scl_oe              <= 1'b0;
            sda_oe              <= 1'b0;
            start_enable        <= 1'b0;
            stop_enable_bit     <= 1'b0;
            receive_enable_bit  <= 1'b0;
            ack_sequence_enable <= 1'b0;
            state               <= ST_IDLE;
         end
      end
   end

   // ----------------------------------------------------------------
   // Pin data and processor signalling.
   // ----------------------------------------------------------------
   // Open-drain lines only ever drive low, so the data outputs stay 0.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_out  <= 1'b0;
         sda_out  <= 1'b0;
         port_irq <= 1'b0;
         wake     <= 1'b0;
      end else begin
         scl_out  <= 1'b0;
         sda_out  <= 1'b0;
         port_irq <= irq_en & port_event_flag;
         wake     <= sleep_mode & irq_en & port_event_flag;
      end
   end

endmodule

// file: bench/i2c_slave_model.sv
`timescale 1ns/10ps
// Slave that sends tx_byte MSB first; bit eight is its ack slot.
module i2c_slave_model (
   input  wire logic       clk,
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic [7:0] tx_byte,
   output logic            scl_oe = 1'b0,
   output logic            sda_oe = 1'b0
);
   logic       scl_q = 1'b1, sda_q = 1'b1;
   logic [3:0] bit_n = 4'h0, hold = 4'h0;
   // Odd bits are stretched so both quick and slow answers occur.
   always @(posedge clk) begin
      scl_q <= scl;
      sda_q <= sda;
      hold <= (hold != 0) ? hold - 4'h1 : 4'h0;
      scl_oe <= hold != 0;
      if (scl_q && sda_q && !sda) bit_n <= 4'h0;
      if (scl_q && !scl) begin
         hold <= bit_n[0] ? 4'h6 : 4'h0;
         sda_oe <= bit_n < 8 && !tx_byte[7 - bit_n];
         bit_n <= bit_n < 8 ? bit_n + 4'h1 : 4'h0;
      end
   end
endmodule

// file: bench/i2c_master_seq_monitor.sv
`timescale 1ns/10ps
module i2c_master_seq_monitor
   import i2c_seq_pkg::*;
(
   input wire logic               pclk,
   input wire logic               presetn,
   input wire logic               pwrite,
   input wire logic [PADDR_W-1:0] paddr,
   input wire logic [PDATA_W-1:0] pwdata,
   input wire logic [PDATA_W-1:0] prdata,
   input wire logic               pready,
   input wire logic               scl_in,
   input wire logic               sda_in,
   input wire logic               scl_oe,
   input wire logic               sda_oe,
   input wire logic               sleep_mode,
   input wire logic               port_irq,
   input wire logic               wake
);
   logic en;
   wire  ctl = pready && pwrite && paddr == OFF_CTRL;
   wire  st_rd = pready && !pwrite && paddr == OFF_STAT;
   // Port enable as software last wrote it.
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) en <= 1'b0;
      else if (ctl) en <= pwdata[C_PORT_EN];
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   off_release_a: assert property ((!en)[*2] |-> !scl_oe && !sda_oe)
      else $error("line held while port off");
   seen_clear_a: assert property (st_rd && !en |-> !prdata[6:5])
      else $error("seen flag while port off");
   bus_free_a: assert property (st_rd |->
      prdata[7] == (prdata[6] || !prdata[5]))
      else $error("bus free flag wrong");
   wake_cause_a: assert property (wake |-> port_irq && $past(sleep_mode))
      else $error("wake without cause");
   stretch_wait_a: assert property (!scl_oe && !scl_in |=> !scl_oe)
      else $error("clock pulled before it read high");
   start_end_a: assert property ($rose(sda_oe) && scl_in && !scl_oe
      |-> ##[1:300] scl_oe)
      else $error("start never pulled clock low");
   low_start_a: assert property (ctl && pwdata[C_START]
      && !(scl_in && sda_in) && !sda_oe |=> (!sda_oe)[*8])
      else $error("start driven on low bus");
   stop_gap_a: assert property ($fell(sda_oe) && scl_in
      |-> !$past(scl_oe, 4))
      else $error("stop released data too soon");
endmodule
bind i2c_master_seq i2c_master_seq_monitor i2c_master_seq_monitor_i (.*);

// file: bench/i2c_master_rx_ack_stop_arbitration_test.sv
`timescale 1ns/10ps
module i2c_master_rx_ack_stop_arbitration_test;
   import i2c_seq_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
   logic sleep_mode = 0, pull_sda = 0, pready, pslverr, scl_oe, sda_oe;
   logic port_irq, wake, m_scl_oe, m_sda_oe, scl_o, sda_o;
   logic [7:0] paddr = 0, tx_byte = 8'hA5;
   logic [31:0] pwdata = 0, prdata, r;
   logic [7:0] b [4] = '{8'hA5, 8'h3C, 8'hC3, 8'hFF};
   logic [40:0] rows [5] = '{{OFF_CTRL, 33'h0}, {OFF_STAT, 33'h80},
      {OFF_DATA, 33'h0}, {OFF_RATE, 26'h0, RATE_RST}, {8'h10, 33'h100000000}};
   int errors = 0, n_checks = 0;
   wire scl_w = !(scl_oe | m_scl_oe);
   wire sda_w = !(sda_oe | m_sda_oe | pull_sda);
   i2c_master_seq i2c_master_seq_i (.*, .scl_in(scl_w), .sda_in(sda_w),
      .scl_out(scl_o), .sda_out(sda_o));
   i2c_slave_model i2c_slave_model_i (.clk(pclk), .scl(scl_w), .sda(sda_w),
      .tx_byte(tx_byte), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));
   initial forever #4 pclk = ~pclk;
   task automatic check(input logic [32:0] s, input logic [32:0] x);
      n_checks++;
      if (s !== x) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, x);
      end
   endtask
   // One APB transfer; held until pready is seen high.
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] q, output logic er);
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      er = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic idle();
      repeat (300) begin
         apb(0, OFF_STAT, 0, r, e);
         if (r[S_BUSY] === 1'b0) return;
      end
      check(1, 0);
   endtask
   task automatic rows_check();
      foreach (rows[i]) begin
         apb(0, rows[i][40:33], 0, r, e);
         check({e, r}, rows[i][32:0]);
      end
   endtask
   task automatic report_and_stop();
      $display("errors %0d checks %0d", errors, n_checks);
      if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #200000 errors++;
      report_and_stop();
   end
   // Three bytes: the last lands on a full buffer and is not acked.
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1;
      rows_check();
      sleep_mode <= 1;
      apb(1, OFF_CTRL, 32'h41, r, e);
      apb(1, OFF_CTRL, 32'h43, r, e);
      idle();
      for (int k = 0; k < 3; k++) begin
         apb(1, OFF_CTRL, 32'h49, r, e);
         apb(1, OFF_DATA, 32'h5A, r, e);
         idle();
         apb(0, OFF_STAT, 0, r, e);
         check(r[2:0], {1'b1, k == 2, 1'b1});
         if (k == 0) begin
            check(wake, 1);
            apb(0, OFF_DATA, 0, r, e);
            check(r, b[0]);
            apb(0, OFF_STAT, 0, r, e);
            check(r[S_BF], 0);
         end
         tx_byte <= b[k + 1];
         apb(1, OFF_CTRL, k == 2 ? 32'h61 : 32'h41, r, e);
         apb(1, OFF_CTRL, k == 2 ? 32'h71 : 32'h51, r, e);
         @(posedge scl_w);
         check(sda_w, k == 2);
         idle();
      end
      apb(1, OFF_STAT, 32'h1E, r, e);
      apb(1, OFF_CTRL, 32'h45, r, e);
      idle();
      apb(0, OFF_STAT, 0, r, e);
      check(r & 32'hD0, 32'hD0);
      pull_sda <= 1;
      apb(1, OFF_CTRL, 32'h43, r, e);
      idle();
      apb(0, OFF_STAT, 0, r, e);
      check({r[S_BCOL], scl_oe, sda_oe}, 3'h4);
      apb(1, OFF_STAT, 32'h1E, r, e);
      pull_sda <= 0;
      repeat (4) @(posedge pclk);
      apb(0, OFF_STAT, 0, r, e);
      check(r[S_EVT], 1);
      apb(1, OFF_CTRL, 32'h43, r, e);
      idle();
      // A released data bit pulled low by another master.
      pull_sda <= 1;
      apb(1, OFF_DATA, 32'hFF, r, e);
      idle();
      apb(0, OFF_STAT, 0, r, e);
      check({r[S_BCOL], r[S_BF], scl_oe, sda_oe}, 4'h8);
      pull_sda <= 0;
      repeat (4) @(posedge pclk);
      apb(1, OFF_CTRL, 32'h49, r, e);
      repeat (30) @(posedge pclk);
      presetn <= 0;
      repeat (8) @(posedge pclk);
      check({scl_oe, sda_oe, scl_o, sda_o}, 0);
      presetn <= 1;
      rows_check();
      report_and_stop();
   end
endmodule
